//--- core/svc_defines.vh
// shared constants for the bus-programmed voltage code controller
`ifndef SVC_DEFINES_VH
`define SVC_DEFINES_VH

// bus slave address, 8-bit write form E2H, 7-bit form below
`define SVC_ADDR7 7'h71

// voltage code register width and power-on value
`define SVC_CODE_W 5
`define SVC_CODE_RESET 5'h1F

// command byte encodings, neutral defaults
`define SVC_CMD_SETUP 8'h01
`define SVC_CMD_ON 8'h02
`define SVC_CMD_OFF 8'h03
`define SVC_CMD_READ 8'h04

// settling interval and clock period
`define SVC_SETTLE_NS 50000
`define SVC_CLK_PERIOD_PS 25000
`define SVC_TMR_W 12

// pending pair tracking codes
`define SVC_PEND_NONE 2'h0
`define SVC_PEND_ON 2'h1
`define SVC_PEND_OFF 2'h2

// output level steps in millivolts
`define SVC_MV_LOW_TOP 12'h802
`define SVC_MV_LOW_STEP 12'h032
`define SVC_MV_HIGH_TOP 12'hDAC
`define SVC_MV_HIGH_STEP 12'h064
`define SVC_MV_ALL_ONES 12'h7D0

`endif

//--- core/svc_smbus_slave.v
// word read/write bus slave engine, oversampled on the system clock
`timescale 1ns/1ps
`include "svc_defines.vh"

module svc_smbus_slave #(
	parameter [6:0] ADDR = `SVC_ADDR7
) (
	// clock and reset
	input wire clk,
	input wire reset,
	// synchronised bus lines
	input wire scl_s,
	input wire sda_s,
	output reg sda_oe_reg,
	// read-back bytes
	input wire [7:0] tx_lo,
	input wire [7:0] tx_hi,
	// transaction events
	output reg evt_wr_reg,
	output reg evt_rd_reg,
	output reg full_reg,
	output reg [7:0] cmd_reg,
	output reg [7:0] dlo_reg,
	output reg [7:0] dhi_reg
);

	localparam ST_IDLE = 3'h0;
	localparam ST_RX = 3'h1;
	localparam ST_ACK = 3'h2;
	localparam ST_TX = 3'h3;
	localparam ST_TACK = 3'h4;

	reg [2:0] state_reg;
	reg [3:0] bit_reg;
	reg [7:0] sh_reg;
	reg [1:0] nbyte_reg;
	reg addr_ph_reg;
	reg mine_reg;
	reg rd_reg;
	reg txsel_reg;
	reg scl_q_reg;
	reg sda_q_reg;

	wire start = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
	wire stop = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
	wire rise = scl_s & ~scl_q_reg;
	wire fall = ~scl_s & scl_q_reg;
	wire [7:0] tx_byte = txsel_reg ? tx_hi : tx_lo;

	always @(posedge clk) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			bit_reg <= 4'h0;
			sh_reg <= 8'h00;
			nbyte_reg <= 2'h0;
			addr_ph_reg <= 1'b0;
			mine_reg <= 1'b0;
			rd_reg <= 1'b0;
			txsel_reg <= 1'b0;
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
			sda_oe_reg <= 1'b0;
			evt_wr_reg <= 1'b0;
			evt_rd_reg <= 1'b0;
			full_reg <= 1'b0;
			cmd_reg <= 8'h00;
			dlo_reg <= 8'h00;
			dhi_reg <= 8'h00;
		end else begin
			scl_q_reg <= scl_s;
			sda_q_reg <= sda_s;
			evt_wr_reg <= 1'b0;
			evt_rd_reg <= 1'b0;
			if (start) begin
				// repeated start keeps the command byte already taken
				state_reg <= ST_RX;
				bit_reg <= 4'h0;
				addr_ph_reg <= 1'b1;
				sda_oe_reg <= 1'b0;
			end else if (stop) begin
				if (mine_reg & ~rd_reg) begin
					evt_wr_reg <= 1'b1;
					full_reg <= (nbyte_reg == 2'h3);
				end
				state_reg <= ST_IDLE;
				sda_oe_reg <= 1'b0;
				mine_reg <= 1'b0;
				rd_reg <= 1'b0;
				nbyte_reg <= 2'h0;
			end else begin
				case (state_reg)
				ST_RX: begin
					// sample on the rising bus clock edge
					if (rise && bit_reg != 4'h8) begin
						sh_reg <= {sh_reg[6:0], sda_s};
						bit_reg <= bit_reg + 4'h1;
					end else if (fall && bit_reg == 4'h8) begin
						addr_ph_reg <= 1'b0;
						if (addr_ph_reg) begin
							if (sh_reg[7:1] == ADDR) begin
								sda_oe_reg <= 1'b1;
								mine_reg <= 1'b1;
								rd_reg <= sh_reg[0];
								evt_rd_reg <= sh_reg[0];
								txsel_reg <= 1'b0;
								state_reg <= ST_ACK;
							end else begin
								// other slaves are left alone
								mine_reg <= 1'b0;
								state_reg <= ST_IDLE;
							end
						end else begin
							case (nbyte_reg)
							2'h0: cmd_reg <= sh_reg;
							2'h1: dlo_reg <= sh_reg;
							2'h2: dhi_reg <= sh_reg;
							default: ;
							endcase
							if (nbyte_reg != 2'h3)
								nbyte_reg <= nbyte_reg + 2'h1;
							sda_oe_reg <= 1'b1;
							state_reg <= ST_ACK;
						end
					end
				end
				ST_ACK: begin
					if (fall) begin
						if (rd_reg) begin
							// drive data out on the falling edge
							sda_oe_reg <= ~tx_byte[7];
							sh_reg <= {tx_byte[6:0], 1'b0};
							bit_reg <= 4'h1;
							state_reg <= ST_TX;
						end else begin
							sda_oe_reg <= 1'b0;
							bit_reg <= 4'h0;
							state_reg <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (fall) begin
						if (bit_reg == 4'h8) begin
							sda_oe_reg <= 1'b0;
							state_reg <= ST_TACK;
						end else begin
							sda_oe_reg <= ~sh_reg[7];
							sh_reg <= {sh_reg[6:0], 1'b0};
							bit_reg <= bit_reg + 4'h1;
						end
					end
				end
				ST_TACK: begin
					if (rise) begin
						if (sda_s) begin
							state_reg <= ST_IDLE;
						end else begin
							txsel_reg <= 1'b1;
							state_reg <= ST_ACK;
						end
					end
				end
				default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

endmodule // svc_smbus_slave

//--- core/svc_top.v
// on/off command interpreter, voltage code registers and settling timer
`timescale 1ns/1ps
`include "svc_defines.vh"

module svc_top #(
	parameter [7:0] CMD_SETUP = `SVC_CMD_SETUP,
	parameter [7:0] CMD_ON = `SVC_CMD_ON,
	parameter [7:0] CMD_OFF = `SVC_CMD_OFF,
	parameter [7:0] CMD_READ = `SVC_CMD_READ,
	parameter SETTLE_NS = `SVC_SETTLE_NS,
	parameter CLK_PERIOD_PS = `SVC_CLK_PERIOD_PS
) (
	// clock and reset
	input wire clk,
	input wire reset,
	// serial bus pins
	input wire scl_in,
	input wire sda_in,
	output reg sda_out_reg,
	output reg sda_oe_reg,
	// control pins
	input wire regulator_enable_in,
	input wire setting_select,
	// soft-start pull-down, open drain
	input wire softstart_pull_down_in,
	output reg softstart_pull_down_out_reg,
	output reg softstart_pull_down_oe_reg,
	// settling timer, open drain
	input wire settle_timer_out_in,
	output reg settle_timer_out_out_reg,
	output reg settle_timer_out_oe_reg,
	// status and active divider setting
	output reg converter_off_status_reg,
	output reg bus_on_state_reg,
	output reg [`SVC_CODE_W-1:0] voltage_code_reg,
	output reg [11:0] output_mv_reg
);

	// least time rounds up to whole cycles
	localparam integer SETTLE_CYC_I = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam [`SVC_TMR_W-1:0] SETTLE_CYC = SETTLE_CYC_I[`SVC_TMR_W-1:0];

	// pin synchronisers
	reg scl_m_reg, scl_s_reg;
	reg sda_m_reg, sda_s_reg;
	reg en_m_reg, en_s_reg;
	reg sel_m_reg, sel_s_reg, sel_q_reg;

	// command state
	reg [`SVC_CODE_W-1:0] voltage_code_low_sel_reg;
	reg [`SVC_CODE_W-1:0] voltage_code_high_sel_reg;
	reg setup_done_reg;
	reg [1:0] pend_reg;
	reg on_q_reg;
	reg [`SVC_TMR_W-1:0] tmr_reg;

	wire slv_oe;
	wire evt_wr;
	wire evt_rd;
	wire evt_full;
	wire [7:0] cmd;
	wire [7:0] dlo;
	wire [7:0] dhi;

	wire conv_on = bus_on_state_reg & en_s_reg;
	// read-back: each code followed by the off status bit
	wire [7:0] rb_lo = {2'b00, voltage_code_low_sel_reg, converter_off_status_reg};
	wire [7:0] rb_hi = {2'b00, voltage_code_high_sel_reg, converter_off_status_reg};

	// code to output level, two step ranges and one odd code
	function [11:0] code_to_mv;
		input [`SVC_CODE_W-1:0] code;
		reg [11:0] idx;
		begin
			idx = {8'h00, code[3:0]};
			if (code == `SVC_CODE_RESET)
				code_to_mv = `SVC_MV_ALL_ONES;
			else if (code[4])
				code_to_mv = `SVC_MV_HIGH_TOP - idx * `SVC_MV_HIGH_STEP;
			else
				code_to_mv = `SVC_MV_LOW_TOP - idx * `SVC_MV_LOW_STEP;
		end
	endfunction

	svc_smbus_slave #(
		.ADDR(`SVC_ADDR7)
	) u_slave (
		.clk(clk),
		.reset(reset),
		.scl_s(scl_s_reg),
		.sda_s(sda_s_reg),
		.sda_oe_reg(slv_oe),
		.tx_lo(rb_lo),
		.tx_hi(rb_hi),
		.evt_wr_reg(evt_wr),
		.evt_rd_reg(evt_rd),
		.full_reg(evt_full),
		.cmd_reg(cmd),
		.dlo_reg(dlo),
		.dhi_reg(dhi)
	);

	// bus, enable and select pins pass two flops; a glitch there is not filtered and can decode as a bus edge
	always @(posedge clk) begin
		if (reset) begin
			scl_m_reg <= 1'b1;
			scl_s_reg <= 1'b1;
			sda_m_reg <= 1'b1;
			sda_s_reg <= 1'b1;
			en_m_reg <= 1'b0;
			en_s_reg <= 1'b0;
			sel_m_reg <= 1'b0;
			sel_s_reg <= 1'b0;
			sel_q_reg <= 1'b0;
		end else begin
			scl_m_reg <= scl_in;
			scl_s_reg <= scl_m_reg;
			sda_m_reg <= sda_in;
			sda_s_reg <= sda_m_reg;
			en_m_reg <= regulator_enable_in;
			en_s_reg <= en_m_reg;
			sel_m_reg <= setting_select;
			sel_s_reg <= sel_m_reg;
			sel_q_reg <= sel_s_reg;
		end
	end

	// bus data pin: only ever pulls low
	always @(posedge clk) begin
		if (reset) begin
			sda_out_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else begin
			sda_out_reg <= 1'b0;
			sda_oe_reg <= slv_oe;
		end
	end

	// command interpreter
	always @(posedge clk) begin
		if (reset) begin
			voltage_code_low_sel_reg <= `SVC_CODE_RESET;
			voltage_code_high_sel_reg <= `SVC_CODE_RESET;
			setup_done_reg <= 1'b0;
			pend_reg <= `SVC_PEND_NONE;
			bus_on_state_reg <= 1'b0;
		end else if (evt_rd) begin
			// a read to our address breaks any pair in progress
			pend_reg <= `SVC_PEND_NONE;
		end else if (evt_wr) begin
			if (evt_full && cmd == CMD_SETUP) begin
				// only setup ever latches codes
				if (!conv_on) begin
					voltage_code_low_sel_reg <= dlo[`SVC_CODE_W-1:0];
					voltage_code_high_sel_reg <= dhi[`SVC_CODE_W-1:0];
					setup_done_reg <= 1'b1;
				end
				pend_reg <= `SVC_PEND_NONE;
			end else if (evt_full && cmd == CMD_ON) begin
				// data bytes are dropped here
				if (!setup_done_reg) begin
					pend_reg <= `SVC_PEND_NONE;
				end else if (pend_reg == `SVC_PEND_ON) begin
					bus_on_state_reg <= 1'b1;
					pend_reg <= `SVC_PEND_NONE;
				end else begin
					pend_reg <= `SVC_PEND_ON;
				end
			end else if (evt_full && cmd == CMD_OFF) begin
				if (pend_reg == `SVC_PEND_OFF) begin
					bus_on_state_reg <= 1'b0;
					pend_reg <= `SVC_PEND_NONE;
				end else begin
					pend_reg <= `SVC_PEND_OFF;
				end
			end else begin
				// short or unknown writes to us break a pair
				pend_reg <= `SVC_PEND_NONE;
			end
		end
	end

	// converter control outputs and settling timer
	always @(posedge clk) begin
		if (reset) begin
			converter_off_status_reg <= 1'b1;
			softstart_pull_down_out_reg <= 1'b0;
			softstart_pull_down_oe_reg <= 1'b1;
			settle_timer_out_out_reg <= 1'b0;
			settle_timer_out_oe_reg <= 1'b1;
			on_q_reg <= 1'b0;
			tmr_reg <= SETTLE_CYC;
		end else begin
			on_q_reg <= conv_on;
			softstart_pull_down_out_reg <= 1'b0;
			settle_timer_out_out_reg <= 1'b0;
			converter_off_status_reg <= ~conv_on;
			if (!conv_on) begin
				// enable low wins over bus state
				softstart_pull_down_oe_reg <= 1'b1;
				settle_timer_out_oe_reg <= 1'b1;
				tmr_reg <= SETTLE_CYC;
			end else if (!on_q_reg || (sel_s_reg != sel_q_reg)) begin
				// fresh turn-on or select toggle restarts the count
				softstart_pull_down_oe_reg <= 1'b0;
				settle_timer_out_oe_reg <= 1'b1;
				tmr_reg <= SETTLE_CYC - 1'b1;
			end else if (tmr_reg != {`SVC_TMR_W{1'b0}}) begin
				softstart_pull_down_oe_reg <= 1'b0;
				settle_timer_out_oe_reg <= 1'b1;
				tmr_reg <= tmr_reg - 1'b1;
			end else begin
				softstart_pull_down_oe_reg <= 1'b0;
				settle_timer_out_oe_reg <= 1'b0;
			end
		end
	end

	// active divider setting, 10:5 selection
	always @(posedge clk) begin
		if (reset) begin
			voltage_code_reg <= `SVC_CODE_RESET;
			output_mv_reg <= `SVC_MV_ALL_ONES;
		end else begin
			voltage_code_reg <= sel_s_reg ? voltage_code_high_sel_reg : voltage_code_low_sel_reg;
			output_mv_reg <= code_to_mv(sel_s_reg ? voltage_code_high_sel_reg :
				voltage_code_low_sel_reg);
		end
	end

endmodule // svc_top

//--- tb/svc_properties.sv
// assertions on the converter control outputs
`timescale 1ns/1ps
module svc_props #(
	parameter SETTLE_NS = 50000,
	parameter CLK_PERIOD_PS = 25000
) (
	// clock and reset
	input wire clk,
	input wire reset,
	// control pins
	input wire regulator_enable_in,
	input wire setting_select,
	// watched outputs
	input wire softstart_pull_down_oe_reg,
	input wire settle_timer_out_oe_reg,
	input wire converter_off_status_reg,
	input wire bus_on_state_reg,
	input wire [4:0] voltage_code_reg,
	input wire [11:0] output_mv_reg
);
	localparam int N = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	reg [15:0] run_reg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	function automatic [11:0] lvl(input [4:0] c);
		lvl = (c == 5'h1F) ? 12'h7D0 : c[4] ? 12'hDAC - 12'h064 * c[3:0] : 12'h802 - 12'h032 * c;
	endfunction
	// length of the present low pulse on the timer pin while on
	always @(posedge clk) begin
		if (reset || converter_off_status_reg || !settle_timer_out_oe_reg) begin
			run_reg <= 16'h0000;
		end else begin
			run_reg <= run_reg + 16'h0001;
		end
	end
	sequence s_on_quiet;
		(!converter_off_status_reg && $stable(setting_select)) [*5];
	endsequence
	sequence s_sel_edge;
		!converter_off_status_reg [*3] ##0 $changed(setting_select);
	endsequence
	AST_PULLDOWN: assert property (softstart_pull_down_oe_reg == converter_off_status_reg)
		else $error("pull-down differs from off status");
	AST_ENABLE_LOW: assert property (!regulator_enable_in [*5] |-> converter_off_status_reg && settle_timer_out_oe_reg)
		else $error("enable low did not force off");
	AST_OFF_STATUS: assert property ((!bus_on_state_reg [*2] |-> converter_off_status_reg) and ((bus_on_state_reg && regulator_enable_in) [*5] |-> !converter_off_status_reg))
		else $error("off status wrong");
	AST_TIMER_OFF: assert property (converter_off_status_reg [*2] |-> settle_timer_out_oe_reg)
		else $error("timer released while off");
	AST_SETTLE_LEN: assert property ((run_reg <= N + 1) and ($fell(settle_timer_out_oe_reg) |-> run_reg >= N - 1))
		else $error("settling pulse length wrong");
	AST_RETRIGGER: assert property (s_sel_edge |-> ##[1:8] settle_timer_out_oe_reg)
		else $error("select toggle did not retrigger timer");
	AST_LEVEL: assert property ($stable(voltage_code_reg) |-> output_mv_reg == lvl(voltage_code_reg))
		else $error("level does not match code");
	AST_LOCKED: assert property (s_on_quiet |=> $stable(voltage_code_reg))
		else $error("code changed while on");
endmodule // svc_props
bind svc_top svc_props #(.SETTLE_NS(SETTLE_NS), .CLK_PERIOD_PS(CLK_PERIOD_PS)) chk_u (.*);

//--- tb/svc_bus_master.sv
// bus master model for word write and word read
`timescale 1ns/1ps
module svc_bus_master (
	// clock
	input wire clk,
	// bus lines, sda pulled low while sda_low_reg is high
	output reg scl_reg,
	output reg sda_low_reg,
	input wire sda
);
	initial begin
		scl_reg = 1'b1;
		sda_low_reg = 1'b0;
	end
	task wt(input integer n);
		repeat (n) @(negedge clk);
	endtask
	// scl low 5 cycles so the slave has time to answer
	task bt(input b, output r);
		begin
			wt(1);
			sda_low_reg = !b;
			wt(4);
			scl_reg = 1'b1;
			wt(3);
			r = sda;
			scl_reg = 1'b0;
		end
	endtask
	// start when p is 0, stop when p is 1
	task cond(input p);
		begin
			if (!scl_reg) begin
				wt(1);
				sda_low_reg = p;
				wt(4);
				scl_reg = 1'b1;
				wt(3);
			end
			sda_low_reg = !p;
			wt(4);
			scl_reg = p;
			wt(4);
		end
	endtask
	task byte_x(input [7:0] d, input m, output [7:0] r, output a);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				bt(d[i], r[i]);
			end
			bt(m, a);
		end
	endtask
	task wr(input [7:0] ad, input [7:0] c, input [7:0] lo, input [7:0] hi, output a);
		reg [7:0] r;
		reg x;
		begin
			cond(1'b0);
			byte_x(ad, 1'b1, r, a);
			byte_x(c, 1'b1, r, x);
			byte_x(lo, 1'b1, r, x);
			byte_x(hi, 1'b1, r, x);
			cond(1'b1);
		end
	endtask
	task rd(output [7:0] lo, output [7:0] hi);
		reg [7:0] r;
		reg x;
		begin
			cond(1'b0);
			byte_x(8'hE2, 1'b1, r, x);
			byte_x(8'h04, 1'b1, r, x);
			cond(1'b0);
			byte_x(8'hE3, 1'b1, r, x);
			byte_x(8'hFF, 1'b0, lo, x);
			byte_x(8'hFF, 1'b1, hi, x);
			cond(1'b1);
		end
	endtask
endmodule // svc_bus_master

//--- tb/svc_smbus_vid_onoff_control_test.sv
// self-checking bench for the on/off interpreter and code registers
`timescale 1ns/1ps
module svc_smbus_vid_onoff_control_test;
	reg clk = 1'b0;
	reg reset = 1'b1;
	reg enable = 1'b1;
	reg sel = 1'b0;
	reg ak;
	reg [7:0] lo;
	reg [7:0] hi;
	integer errors = 0;
	integer compares = 0;
	integer c;
	wire scl;
	wire sda_low;
	wire sda_oe;
	wire sda_o;
	wire ss_o;
	wire tm_o;
	wire ss_oe;
	wire tm_oe;
	wire off_st;
	wire on_st;
	wire [4:0] code;
	wire [11:0] mv;
	wire sda = !(sda_low || sda_oe);
	always #12.5 clk = !clk;
	svc_top #(.SETTLE_NS(1000)) dut_u (
		.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
		.sda_out_reg(sda_o), .sda_oe_reg(sda_oe),
		.regulator_enable_in(enable), .setting_select(sel),
		.softstart_pull_down_in(!ss_oe), .softstart_pull_down_out_reg(ss_o),
		.softstart_pull_down_oe_reg(ss_oe),
		.settle_timer_out_in(!tm_oe), .settle_timer_out_out_reg(tm_o),
		.settle_timer_out_oe_reg(tm_oe),
		.converter_off_status_reg(off_st), .bus_on_state_reg(on_st),
		.voltage_code_reg(code), .output_mv_reg(mv)
	);
	svc_bus_master bm_u (.clk(clk), .scl_reg(scl), .sda_low_reg(sda_low), .sda(sda));
	task chk(input [47:0] nm, input [31:0] s, input [31:0] e);
		begin
			compares = compares + 1;
			if (s !== e) begin
				errors = errors + 1;
				$display("wrong value %0s expected %0h seen %0h", nm, e, s);
			end
		end
	endtask
	task st(input [3:0] e);
		chk("status", {off_st, on_st, ss_oe, tm_oe}, e);
	endtask
	task w(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task wr(input [7:0] cm, input [7:0] d0, input [7:0] d1);
		bm_u.wr(8'hE2, cm, d0, d1, ak);
	endtask
	task conclude;
		begin
			$display("compares %0d errors %0d", compares, errors);
			if (errors == 0 && compares > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// the longest run is about 15k cycles
	initial begin
		#(25 * 60000);
		errors = errors + 1;
		conclude;
	end
	initial begin
		w(3);
		reset = 1'b0;
		w(4);
		st(4'b1011);
		chk("code", code, 5'h1F);
		chk("drains", {sda_o, ss_o, tm_o}, 3'h0);
		bm_u.rd(lo, hi);
		chk("rd", {lo, hi}, 16'h3F3F);
		wr(8'h02, 8'h00, 8'h00);
		wr(8'h02, 8'h00, 8'h00);
		w(4);
		st(4'b1011);
		chk("ack", ak, 0);
		$display("power-up test done");
		for (c = 0; c < 32; c = c + 1) begin
			wr(8'h01, c, 31 - c);
			w(4);
			chk("code", code, c);
			chk("mv", mv, (c == 31) ? 2000 : (c < 16) ? 2050 - 50 * c : 3500 - 100 * (c - 16));
		end
		wr(8'h01, 8'h00, 8'h10);
		bm_u.rd(lo, hi);
		chk("rd", {lo, hi}, 16'h0121);
		$display("code test done");
		wr(8'h02, 8'h15, 8'h15);
		bm_u.wr(8'hA0, 8'h03, 8'h00, 8'h00, ak);
		chk("ack", ak, 1);
		st(4'b1011);
		wr(8'h02, 8'h15, 8'h15);
		w(4);
		st(4'b0101);
		chk("code", code, 5'h00);
		w(40);
		st(4'b0100);
		wr(8'h01, 8'h05, 8'h05);
		w(4);
		chk("code", code, 5'h00);
		bm_u.rd(lo, hi);
		chk("rd", {lo, hi}, 16'h0020);
		sel = 1'b1;
		w(6);
		chk("code", code, 5'h10);
		st(4'b0101);
		w(45);
		st(4'b0100);
		$display("turn-on test done");
		enable = 1'b0;
		w(6);
		st(4'b1111);
		wr(8'h01, 8'h02, 8'h11);
		w(4);
		chk("mv", mv, 3400);
		enable = 1'b1;
		w(6);
		st(4'b0101);
		w(45);
		st(4'b0100);
		$display("enable test done");
		wr(8'h03, 8'h00, 8'h00);
		wr(8'h02, 8'h00, 8'h00);
		wr(8'h03, 8'h00, 8'h00);
		w(4);
		st(4'b0100);
		wr(8'h03, 8'h00, 8'h00);
		w(4);
		st(4'b1011);
		chk("drains", {sda_o, ss_o, tm_o}, 3'h0);
		$display("turn-off test done");
		conclude;
	end
endmodule // svc_smbus_vid_onoff_control_test
